/* File: hdl/mitc_master.v */
// two-wire bus master that reads and writes the magnetometer's registers
// ------------------------------------------------------------
// How it works
// - idle: both lines released and resting high; bus free
// - start: data falls while clock high; bus busy afterwards
// - first byte: seven address bits then direction bit
// - ninth clock of every byte is the acknowledge slot
// - transmitter releases data during the acknowledge slot
// - receiver holds data low through acknowledge clock high phase
// - no upper limit on bytes after the address byte; cmd_len caps one command at 255 data bytes
// - target may hold clock low; master waits for release
// - stop: data rises while clock high, ends the transaction
// - every write command ends with a stop; the register write of a read ends with a repeated start
// - read ends with last byte not acknowledged
// - repeated start allowed without stop; address reception restarts
// - read: register address written, repeated start, read direction
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "mitc_defs.vh"
module mitc_master (
    // clock and reset
    input  wire       clk,
    input  wire       resetn,
    // command
    input  wire       cmd_valid,
    output wire       cmd_ready,
    input  wire       cmd_read,
    input  wire       alt_addr,
    input  wire       fast_mode,
    input  wire [7:0] cmd_reg,
    input  wire [7:0] cmd_len,
    // write data stream
    input  wire [7:0] wr_data,
    output reg        wr_take,
    // read data stream
    output reg  [7:0] rd_data,
    output reg        rd_valid,
    // status
    output reg        busy,
    output reg        done,
    output reg        nak_err,
    // bus pins, enable low drives low
    input  wire       scl_in,
    output wire       scl_out,
    output reg        scl_oen,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oen
);
    // ------------------------------------------------------------
    // synchronised lines
    // ------------------------------------------------------------
    wire [1:0] lines;
    wire       scl_s = lines[1];
    wire       sda_s = lines[0];

    mitc_sync u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in ({scl_in, sda_in}),
        .sync_out (lines)
    );

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [3:0]             state;
    reg [1:0]             phase;
    reg [`MITC_CNT_W-1:0] cnt;
    reg [`MITC_CNT_W-1:0] qtr;
    reg [7:0]             shift;
    reg [3:0]             bitn;
    reg [1:0]             stage;    // 0 addr-w, 1 reg, 2 data, 3 addr-r/rdata
    reg                   is_read;
    reg                   rd_phase;
    reg [7:0]             left;
    reg                   acked;

    assign cmd_ready = (state == `MITC_ST_IDLE);

    function [7:0] addr_byte;
        input alt;
        input dir;
        begin
            addr_byte = {(alt ? `MITC_ADDR_ALT
                              : `MITC_ADDR_STD), dir};
        end
    endfunction

    wire tick = (cnt == {`MITC_CNT_W{1'b0}});
    // quarter counts cut to the counter width on purpose
    wire [31:0]             qtr_fast_full = `MITC_QTR_FAST;
    wire [31:0]             qtr_norm_full = `MITC_QTR_NORM;
    wire [`MITC_CNT_W-1:0]  qtr_fast      = qtr_fast_full[`MITC_CNT_W-1:0];
    wire [`MITC_CNT_W-1:0]  qtr_norm      = qtr_norm_full[`MITC_CNT_W-1:0];
    // a released clock that still reads low freezes the quarter count,
    // so a start or repeated start never falls while the target holds it
    wire stretched = scl_oen && !scl_s;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state    <= `MITC_ST_IDLE;
            phase    <= 2'h0;
            cnt      <= {`MITC_CNT_W{1'b0}};
            qtr      <= {`MITC_CNT_W{1'b0}};
            shift    <= 8'h00;
            bitn     <= 4'h0;
            stage    <= 2'h0;
            is_read  <= 1'b0;
            rd_phase <= 1'b0;
            left     <= 8'h00;
            acked    <= 1'b0;
            scl_oen  <= 1'b1;
            sda_oen  <= 1'b1;
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
            wr_take  <= 1'b0;
            busy     <= 1'b0;
            done     <= 1'b0;
            nak_err  <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            wr_take  <= 1'b0;
            done     <= 1'b0;
            if (!tick && !stretched)
                cnt <= cnt - 1'b1;
            case (state)
            `MITC_ST_IDLE: begin
                scl_oen <= 1'b1;
                sda_oen <= 1'b1;
                busy    <= 1'b0;
                if (cmd_valid && scl_s && sda_s) begin
                    qtr      <= fast_mode ? qtr_fast
                                          : qtr_norm;
                    cnt      <= fast_mode ? qtr_fast
                                          : qtr_norm;
                    is_read  <= cmd_read;
                    left     <= cmd_len;
                    shift    <= addr_byte(alt_addr,
                                          `MITC_DIR_WRITE);
                    stage    <= 2'h0;
                    rd_phase <= 1'b0;
                    nak_err  <= 1'b0;
                    busy     <= 1'b1;
                    phase    <= 2'h0;
                    state    <= `MITC_ST_START;
                end
            end
            `MITC_ST_START, `MITC_ST_RSTART: if (tick) begin
                cnt   <= qtr;
                phase <= phase + 1'b1;
                case (phase)
                2'h0: begin sda_oen <= 1'b1; scl_oen <= 1'b1; end
                2'h1: sda_oen <= 1'b0;
                2'h2: scl_oen <= 1'b0;
                default: begin
                    bitn  <= 4'h0;
                    state <= `MITC_ST_BIT;
                end
                endcase
            end
            `MITC_ST_BIT: if (tick) begin
                cnt   <= qtr;
                phase <= phase + 1'b1;
                case (phase)
                2'h0: begin
                    // receiving while reading data, else sending the byte
                    if (rd_phase) sda_oen <= 1'b1;
                    else sda_oen <= shift[7];
                end
                2'h1: scl_oen <= 1'b1;
                2'h2: if (rd_phase) shift <= {shift[6:0], sda_s};
                default: begin
                    scl_oen <= 1'b0;
                    if (!rd_phase) shift <= {shift[6:0], 1'b0};
                    bitn <= bitn + 1'b1;
                    if (bitn == 4'h7) state <= `MITC_ST_ACK;
                end
                endcase
            end
            `MITC_ST_ACK: if (tick) begin
                cnt   <= qtr;
                phase <= phase + 1'b1;
                case (phase)
                2'h0: begin
                    if (rd_phase)
                        sda_oen <= (left == 8'h01);
                    else
                        sda_oen <= 1'b1;
                end
                2'h1: scl_oen <= 1'b1;
                2'h2: acked <= rd_phase ? 1'b1 : !sda_s;
                default: begin
                    scl_oen <= 1'b0;
                    state   <= `MITC_ST_NEXT;
                end
                endcase
            end
            `MITC_ST_NEXT: begin
                bitn <= 4'h0;
                if (rd_phase) begin
                    rd_data  <= shift;
                    rd_valid <= 1'b1;
                    left     <= left - 1'b1;
                    if (left == 8'h01) state <= `MITC_ST_STOP;
                    else state <= `MITC_ST_BIT;
                end else if (!acked) begin
                    nak_err <= 1'b1;
                    state   <= `MITC_ST_STOP;
                end else if (stage == 2'h0) begin
                    shift <= cmd_reg;
                    stage <= 2'h1;
                    state <= `MITC_ST_BIT;
                end else if (stage == 2'h3) begin
                    rd_phase <= 1'b1;
                    state    <= (left == 8'h00) ? `MITC_ST_STOP
                                                : `MITC_ST_BIT;
                end else if (is_read) begin
                    shift <= addr_byte(alt_addr, `MITC_DIR_READ);
                    stage <= 2'h3;
                    state <= `MITC_ST_RSTART;
                end else if (left == 8'h00) begin
                    state <= `MITC_ST_STOP;
                end else begin
                    shift   <= wr_data;
                    wr_take <= 1'b1;
                    left    <= left - 1'b1;
                    stage   <= 2'h2;
                    state   <= `MITC_ST_BIT;
                end
                phase <= 2'h0;
                cnt   <= qtr;
            end
            `MITC_ST_STOP: if (tick) begin
                cnt   <= qtr;
                phase <= phase + 1'b1;
                case (phase)
                2'h0: sda_oen <= 1'b0;
                2'h1: scl_oen <= 1'b1;
                2'h2: sda_oen <= 1'b1;
                default: state <= `MITC_ST_WAITB;
                endcase
            end
            `MITC_ST_WAITB: if (tick) begin
                done  <= 1'b1;
                state <= `MITC_ST_IDLE;
            end
            default: state <= `MITC_ST_IDLE;
            endcase
        end
    end
endmodule // mitc_master

/* File: common/mitc_defs.vh */
// constants of the two-wire bus master for the magnetometer target port
`ifndef MITC_DEFS_VH
`define MITC_DEFS_VH

// ------------------------------------------------------------
// bus addresses
// ------------------------------------------------------------
`define MITC_ADDR_STD       7'h0E
`define MITC_ADDR_ALT       7'h0F
`define MITC_DIR_WRITE      1'b0
`define MITC_DIR_READ       1'b1

// ------------------------------------------------------------
// register map of the device outside
// ------------------------------------------------------------
`define MITC_REG_DATA_FIRST 8'h01
`define MITC_REG_DATA_LAST  8'h06
`define MITC_REG_OFS_FIRST  8'h09
`define MITC_REG_OFS_LAST   8'h0E

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define MITC_CLK_MHZ        200
`define MITC_FAST_KHZ       400
`define MITC_NORM_KHZ       100
// quarter of a bus clock period, in system clocks
`define MITC_QTR_FAST       ((`MITC_CLK_MHZ * 1000) / (4 * `MITC_FAST_KHZ))
`define MITC_QTR_NORM       ((`MITC_CLK_MHZ * 1000) / (4 * `MITC_NORM_KHZ))
`define MITC_CNT_W          10

// ------------------------------------------------------------
// master sequencer states
// ------------------------------------------------------------
`define MITC_ST_IDLE        4'h0
`define MITC_ST_START       4'h1
`define MITC_ST_BIT         4'h2
`define MITC_ST_ACK         4'h3
`define MITC_ST_NEXT        4'h4
`define MITC_ST_RSTART      4'h5
`define MITC_ST_STOP        4'h6
`define MITC_ST_WAITB       4'h7

`endif

/* File: hdl/mitc_sync.v */
// two-flop synchroniser for the bus lines
`timescale 1ns/1ps
module mitc_sync (
    // clock and reset
    input  wire       clk,
    input  wire       resetn,
    // asynchronous lines in, synchronised lines out
    input  wire [1:0] async_in,
    output reg  [1:0] sync_out
);
    reg [1:0] meta;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta     <= 2'h3;
            sync_out <= 2'h3;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // mitc_sync

/* File: tb/mitc_master_checker.sv */
// checker of the bus master's port behaviour
`timescale 1ns/1ps
module mitc_master_checker (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // command and status
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic wr_take,
    input wire logic rd_valid,
    input wire logic busy,
    input wire logic done,
    input wire logic nak_err,
    // bus pins
    input wire logic scl_in,
    input wire logic scl_oen,
    input wire logic sda_oen
);
    int unsigned quiet;

    // a stalled sequencer shows as a long quiet spell on both pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            quiet <= 0;
        else if (!busy || (scl_oen && !scl_in) ||
                 $changed(scl_oen) || $changed(sda_oen))
            quiet <= 0;
        else
            quiet <= quiet + 1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_idle_rel; !busy |-> scl_oen && sda_oen; endproperty
    a_idle_rel: assert property (p_idle_rel)
        else $error("bus line held while idle");
    property p_busy; busy && !done |-> !cmd_ready; endproperty
    a_busy: assert property (p_busy)
        else $error("command offered as taken while busy");
    property p_stretch; busy && scl_oen && !scl_in |=> scl_oen; endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock pulled low during target hold");
    property p_done;
        done |-> scl_oen && sda_oen && cmd_ready ##1 !done;
    endproperty
    a_done: assert property (p_done)
        else $error("done without released bus or not a pulse");
    property p_rd; rd_valid |-> busy ##1 !rd_valid; endproperty
    a_rd: assert property (p_rd)
        else $error("read byte strobe outside transfer");
    property p_wr; wr_take |-> busy ##1 !wr_take; endproperty
    a_wr: assert property (p_wr)
        else $error("write byte strobe outside transfer");
    property p_nak; nak_err && !cmd_valid |=> nak_err; endproperty
    a_nak: assert property (p_nak)
        else $error("missing acknowledge flag lost");
    property p_quiet; quiet < 6100; endproperty
    a_quiet: assert property (p_quiet)
        else $error("bus pins stalled beyond bit timing");
endmodule // mitc_master_checker

bind mitc_master mitc_master_checker i_chk (.clk(clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .wr_take(wr_take),
    .rd_valid(rd_valid), .busy(busy), .done(done), .nak_err(nak_err),
    .scl_in(scl_in), .scl_oen(scl_oen), .sda_oen(sda_oen));

/* File: tb/mitc_target_model.sv */
// behavioural magnetometer target on the two-wire bus
`timescale 1ns/1ps
module mitc_target_model #(
    parameter [6:0] ADDR = 7'h0E
) (
    // wire levels
    input  wire        scl,
    input  wire        sda,
    // clock hold after each byte except a read byte left unacknowledged, 0 answers promptly
    input  wire [15:0] hold_ns,
    // pull-downs, high pulls the line low
    output reg         scl_low,
    output reg         sda_low
);
    reg [7:0] mem [0:255];
    reg [7:0] sh;
    reg [7:0] ptr;
    integer   n;
    integer   st;
    reg       tx;
    reg       sel;
    integer   i;

    initial begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = i[7:0] ^ 8'hA5;
        {scl_low, sda_low, tx, sel, ptr, sh} = 0;
        st = 0;
        n = 0;
    end
    always @(negedge sda) if (scl) begin
        st = 1;
        n = -1;
        sda_low = 0;
    end
    always @(posedge sda) if (scl) begin
        st = 0;
        sda_low = 0;
    end
    always @(posedge scl) if (st != 0) begin
        if (n < 8 && (st != 3 || !tx))
            sh = {sh[6:0], sda};
        if (n == 8 && st == 3 && tx && sda)
            st = 0;
    end
    // ----------------------------------------------------------------
    // byte and acknowledge sequencing on the falling clock
    // ----------------------------------------------------------------
    always @(negedge scl) if (st != 0) begin
        n = n + 1;
        if (n == 8) begin
            if (st == 1) begin
                sel = (sh[7:1] == ADDR);
                tx = sh[0];
            end else if (st == 2)
                ptr = sh;
            else if (!tx) begin
                mem[ptr] = sh;
                ptr = ptr + 1;
            end
            sda_low = sel && (st != 3 || !tx);
        end else if (n == 9) begin
            n = 0;
            sda_low = 0;
            if (!sel)
                st = 0;
            else if (st < 3)
                st = st + ((st == 1 && tx) ? 2 : 1);
            if (st == 3 && tx) begin
                sh = mem[ptr];
                ptr = ptr + 1;
            end
            if (hold_ns != 0) begin
                scl_low = 1;
                #(hold_ns);
                scl_low = 0;
            end
        end
        if (st == 3 && tx && n < 8)
            sda_low = !sh[7 - n];
    end
endmodule // mitc_target_model

/* File: tb/tb.sv */
// testbench: bus master against the target model
`timescale 1ns/1ps
`include "mitc_defs.vh"
module tb;
    logic        clk, resetn, cmd_valid, cmd_read, alt_addr, fast_mode;
    logic [7:0]  cmd_reg, cmd_len, wr_data;
    logic [15:0] hold_ns;
    logic [7:0]  got [$];
    logic [7:0]  wq [$];
    wire         cmd_ready, wr_take, rd_valid, busy, done, nak_err;
    wire [7:0]   rd_data;
    wire         scl_oen, sda_oen, m_scl_low, m_sda_low;
    wire         scl = scl_oen & ~m_scl_low;
    wire         sda = sda_oen & ~m_sda_low;
    int          err_total, samples_checked, n_take;

    mitc_master i_mitc_master (.clk(clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .alt_addr(alt_addr), .fast_mode(fast_mode), .cmd_reg(cmd_reg),
        .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .done(done),
        .nak_err(nak_err), .scl_in(scl), .scl_out(), .scl_oen(scl_oen),
        .sda_in(sda), .sda_out(), .sda_oen(sda_oen));
    mitc_target_model #(.ADDR(`MITC_ADDR_STD)) i_mitc_target_model (
        .scl(scl), .sda(sda), .hold_ns(hold_ns),
        .scl_low(m_scl_low), .sda_low(m_sda_low));

    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // offers one command, feeds write bytes, collects read bytes until done
    task automatic run_cmd(logic rd, logic alt, logic fast, logic [7:0] r,
                           logic [7:0] l);
        int k;
        got.delete();
        n_take = 0;
        @(posedge clk);
        {cmd_valid, cmd_read, alt_addr, fast_mode} <= {1'b1, rd, alt, fast};
        {cmd_reg, cmd_len} <= {r, l};
        // the byte must already stand when the master loads it
        wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
        for (k = 0; k < 20 && busy !== 1'b1; k++)
            @(posedge clk);
        cmd_valid <= 1'b0;
        for (k = 0; k < 60000 && done !== 1'b1; k++) begin
            @(posedge clk);
            if (rd_valid === 1'b1)
                got.push_back(rd_data);
            if (wr_take === 1'b1) begin
                n_take++;
                if (wq.size() > 0)
                    void'(wq.pop_front());
                if (wq.size() > 0)
                    wr_data <= wq[0];
            end
        end
        if (done !== 1'b1) begin
            err_total++;
            complete_run();
        end
    endtask
    // unmatched address: no acknowledge, flag raised, no data
    task automatic sc_wrong_addr;
        hold_ns = 0;
        run_cmd(1'b1, 1'b1, 1'b0, 8'h01, 8'h01);
        check("nak_err", nak_err, 8'h01);
        check("rd_count", 8'(got.size()), 8'h00);
    endtask
    // two-byte read with the target stretching after every acknowledged byte
    task automatic sc_burst_read;
        hold_ns = 8000;
        run_cmd(1'b1, 1'b0, 1'b1, 8'h0A, 8'h02);
        check("nak_err", nak_err, 8'h00);
        check("rd_count", 8'(got.size()), 8'h02);
        check("rd_byte0", got.size() > 0 ? got[0] : 8'hXX, 8'hAF);
        check("rd_byte1", got.size() > 1 ? got[1] : 8'hXX, 8'hAE);
        check("ptr", i_mitc_target_model.ptr, 8'h0C);
        check("ready", cmd_ready, 8'h01);
        check("bus_idle", {6'h00, scl, sda}, 8'h03);
    endtask
    // two-byte write into the offset registers at the fast rate
    task automatic sc_burst_write;
        hold_ns = 0;
        wq = '{8'h3C, 8'hC3};
        run_cmd(1'b0, 1'b0, 1'b1, `MITC_REG_OFS_FIRST, 8'h02);
        check("nak_err", nak_err, 8'h00);
        check("wr_count", 8'(n_take), 8'h02);
        check("ofs0", i_mitc_target_model.mem[9], 8'h3C);
        check("ofs1", i_mitc_target_model.mem[10], 8'hC3);
        check("wr_ptr", i_mitc_target_model.ptr, 8'h0B);
        check("stopped", 8'(i_mitc_target_model.st), 8'h00);
    endtask

    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {resetn, cmd_valid, cmd_read, alt_addr, cmd_reg, cmd_len} = 0;
        fast_mode = 1'b1;
        wr_data = 8'h00;
        hold_ns = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        sc_wrong_addr();
        sc_burst_read();
        sc_burst_write();
        complete_run();
    end
endmodule // tb
